// >>> codec_ctrl_pkg.sv
// constants for the telephone codec control interface
// assumes a 100 MHz mclk and an 8 kHz frame sync from the pcm side
package codec_ctrl_pkg;

	// ------------------------------------------------------------
	// register addresses and sub-addresses
	// ------------------------------------------------------------
	localparam logic [1:0] ADDR_SUB     = 2'h0;
	localparam logic [1:0] ADDR_CHAN    = 2'h1;
	localparam logic [1:0] ADDR_KEYS    = 2'h2;
	localparam logic [1:0] ADDR_AUX     = 2'h3;
	localparam logic [1:0] SUB_SOUNDER  = 2'h0;
	localparam logic [1:0] SUB_FKEY     = 2'h1;
	localparam logic [1:0] SUB_PB       = 2'h2;
	localparam logic [1:0] SUB_LATCH    = 2'h3;
	localparam logic [1:0] SUB_VOLCOMBO = 2'h0;
	localparam logic [1:0] SUB_PDOWN    = 2'h1;
	localparam logic [1:0] SUB_LEVELS   = 2'h2;
	localparam logic [1:0] SUB_HOWLER   = 2'h3;

	// ------------------------------------------------------------
	// field positions and codes
	// ------------------------------------------------------------
	localparam int         SUB_MSB       = 7;
	localparam int         LATCH_INT_BIT = 4;
	localparam int         WD_RESTART    = 5;
	localparam int         INT_RELEASE   = 7;
	localparam int         COMBO_LSB     = 2;
	localparam logic [1:0] SND_OFF       = 2'h0;
	localparam logic [1:0] SND_RING      = 2'h1;
	localparam logic [1:0] SND_HOWL      = 2'h2;
	localparam logic [2:0] COMBO_EXT     = 3'h0;
	localparam logic [2:0] COMBO_LAST    = 3'h6;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [5:0] REG6_RESET     = 6'h00;
	localparam logic [7:0] REG8_RESET     = 8'h00;
	localparam logic [5:0] VOLCOMBO_RESET = 6'h03;

	// ------------------------------------------------------------
	// timing, counted in frames of the 8 kHz sync or in mclk cycles
	// ------------------------------------------------------------
	localparam int CLK_NS        = 10;
	localparam int FRAME_HZ      = 8000;
	localparam int FRAME_NS      = 125000;
	localparam int INT_PERIOD_MS = 8;
	localparam int WD_PERIOD_MS  = 500;
	localparam int WD_LOW_MS     = 4;
	localparam int INT_LOW_NS    = 1000;
	localparam logic [5:0] INT_LAST =
		6'(INT_PERIOD_MS * 1000000 / FRAME_NS - 1);
	localparam logic [11:0] WD_LAST =
		12'(WD_PERIOD_MS * 1000000 / FRAME_NS - 1);
	localparam logic [11:0] WD_LOW_START =
		12'((WD_PERIOD_MS - WD_LOW_MS) * 1000000 / FRAME_NS);
	localparam logic [6:0] INT_LOW_CYC = 7'(INT_LOW_NS / CLK_NS);
	localparam logic [8:0] HALF_1000 = 9'(FRAME_HZ / 2000);
	localparam logic [8:0] HALF_1333 = 9'(FRAME_HZ / 2666);
	localparam logic [8:0] HALF_800  = 9'(FRAME_HZ / 1600);
	localparam logic [8:0] WARBLE_16 = 9'(FRAME_HZ / 32);
	localparam logic [8:0] WARBLE_8  = 9'(FRAME_HZ / 16);

	typedef struct packed {
		logic [8:0] f1;
		logic [8:0] f2;
		logic [8:0] warble;
	} tone_s;

endpackage

// >>> pin_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes each bit is an independent level from outside mclk
`timescale 1ns/1ps
module pin_sync #(
	parameter int               W         = 8,
	parameter logic [W-1:0]     RESET_VAL = '0
) (
	input  wire logic           mclk,
	input  wire logic           resetn,
	input  wire logic [W-1:0]   pins,
	output logic      [W-1:0]   pins_s
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_s;

	sync_s sync_reg;
	sync_s sync_next;

	generate
		if (W < 1)
		begin : g_bad
			$error("pin_sync width must be at least one");
		end
	endgenerate

	// first stage is read only by the second stage
	always_comb
	begin
		sync_next    = sync_reg;
		sync_next.s1 = pins;
		sync_next.s2 = sync_reg.s1;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			sync_reg <= {RESET_VAL, RESET_VAL};
		else
			sync_reg <= sync_next;
	end

	assign pins_s = sync_reg.s2;
endmodule // pin_sync

// >>> telephone_control_interface.sv
// processor control interface of the telephone codec
// assumes host pins and the 8 kHz frame sync are asynchronous to mclk
`timescale 1ns/1ps
module telephone_control_interface
	import codec_ctrl_pkg::*;
#(
	parameter int KS_OUT_W = 5
) (
	input  wire logic                mclk,
	input  wire logic                resetn,
	input  wire logic                chip_enable_n,
	input  wire logic                write_n,
	input  wire logic                read_n,
	input  wire logic                reg_addr_bit0,
	input  wire logic                reg_addr_bit1,
	input  wire logic [7:0]          host_data_in,
	output logic      [7:0]          host_data_out,
	output logic                     host_data_oe_n,
	input  wire logic [7:0]          key_scan_inputs,
	output logic      [KS_OUT_W-1:0] key_scan_outputs,
	output logic      [KS_OUT_W-1:0] key_scan_oe_n,
	input  wire logic                tone_combo_select_low,
	input  wire logic                tone_combo_select_high,
	input  wire logic                frame_sync_8k,
	input  wire logic                test_mode,
	input  wire logic                ext_master_clock,
	output logic                     sounder_drive_pos,
	output logic                     sounder_drive_neg,
	output logic      [1:0]          ring_volume,
	output logic      [2:0]          tone_combo,
	output logic      [3:0]          general_latch_outputs,
	output logic                     internal_latch,
	output logic                     howler_flag,
	output logic                     periodic_irq_n,
	output logic                     watchdog_out,
	output logic                     master_clk_ext_sel,
	output logic                     master_clk_ext_level,
	output logic      [5:0]          fkey_tone_ctrl,
	output logic      [5:0]          pb_tone_ctrl,
	output logic      [7:0]          channel_ctrl,
	output logic      [5:0]          power_down_ctrl,
	output logic      [5:0]          level_ctrl,
	output logic      [5:0]          howler_freq_ctrl
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic       frame_prev;
		logic       wr_prev;
		logic [5:0] sounder;
		logic [5:0] fkey;
		logic [5:0] pb;
		logic [5:0] latch;
		logic [7:0] chan;
		logic [7:0] keys;
		logic [5:0] volcombo;
		logic [5:0] pdown;
		logic [5:0] levels;
		logic [5:0] howl;
		logic [5:0] int_cnt;
		logic [6:0] pw_cnt;
		logic       irq_n;
		logic [11:0] wd_cnt;
		logic       wd_out;
		logic [8:0] tone_cnt;
		logic       tone_lvl;
		logic [8:0] warble_cnt;
		logic       warble_ph;
		logic [7:0] rd_data;
		logic       clk_sel;
		logic       clk_level;
	} state_s;

	state_s s_reg;
	state_s s_next;

	generate
		if (KS_OUT_W < 1 || KS_OUT_W > INT_RELEASE)
		begin : g_bad
			$error("key scan output width must be 1 to 7");
		end
	endgenerate

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic       ce_s;
	logic       wr_s;
	logic       rd_s;
	logic [1:0] addr_s;
	logic [7:0] data_s;
	logic [7:0] keys_in_s;
	logic [1:0] sw_s;
	logic       test_s;
	logic       xclk_s;
	logic       frame_s;

	pin_sync #(
		.W         (26),
		.RESET_VAL (26'h0000007)
	) u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.pins   ({frame_sync_8k, test_mode, ext_master_clock,
			tone_combo_select_high, tone_combo_select_low,
			key_scan_inputs, host_data_in, reg_addr_bit1,
			reg_addr_bit0, read_n, write_n, chip_enable_n}),
		.pins_s ({frame_s, test_s, xclk_s, sw_s, keys_in_s, data_s,
			addr_s, rd_s, wr_s, ce_s})
	);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic tone_s tone_for(input logic [2:0] code);
		tone_s t;
		unique case (code)
			3'h1:    t = '{HALF_1000, HALF_1333, WARBLE_16};
			3'h2:    t = '{HALF_800, HALF_1000, WARBLE_16};
			3'h3:    t = '{HALF_800, HALF_1000, WARBLE_8};
			3'h4:    t = '{HALF_800, HALF_1333, WARBLE_16};
			3'h5:    t = '{HALF_1000, HALF_1333, WARBLE_8};
			default: t = '{HALF_800, HALF_1333, WARBLE_8};
		endcase
		return t;
	endfunction

	logic       wr_take;
	logic       frame_tick;
	logic [1:0] sub;
	logic [2:0] pin_code;
	logic [2:0] combo_code;
	logic       ring_on;
	logic       rd_active;
	tone_s      tone;
	logic [8:0] tone_half;

	always_comb
	begin
		// write only counts on the strobe's rising edge while selected
		wr_take    = wr_s && !s_reg.wr_prev && !ce_s;
		frame_tick = frame_s && !s_reg.frame_prev;
		sub        = data_s[SUB_MSB -: 2];
		// pins 00 and 11 share the first pattern
		unique case ({sw_s[0], sw_s[1]})
			2'b01:   pin_code = 3'h2;
			2'b10:   pin_code = 3'h3;
			default: pin_code = 3'h1;
		endcase
		combo_code = s_reg.volcombo[COMBO_LSB +: 3];
		if (combo_code == COMBO_EXT || combo_code > COMBO_LAST)
			combo_code = pin_code;
		tone       = tone_for(combo_code);
		tone_half  = s_reg.warble_ph ? tone.f2 : tone.f1;
		ring_on    = s_reg.sounder[1:0] == SND_RING ||
			s_reg.sounder[1:0] == SND_HOWL;
		rd_active  = !ce_s && !rd_s && addr_s == ADDR_KEYS;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_next            = s_reg;
		s_next.frame_prev = frame_s;
		s_next.wr_prev    = wr_s;
		s_next.rd_data    = keys_in_s;
		s_next.clk_sel    = test_s;
		s_next.clk_level  = test_s && xclk_s;

		if (wr_take)
		begin
			unique case (addr_s)
				ADDR_SUB:
				begin
					unique case (sub)
						SUB_SOUNDER: s_next.sounder = data_s[5:0];
						SUB_FKEY:    s_next.fkey    = data_s[5:0];
						SUB_PB:      s_next.pb      = data_s[5:0];
						SUB_LATCH:   s_next.latch   = data_s[5:0];
					endcase
				end
				ADDR_CHAN: s_next.chan = data_s;
				ADDR_KEYS: s_next.keys = data_s;
				ADDR_AUX:
				begin
					unique case (sub)
						SUB_VOLCOMBO: s_next.volcombo = data_s[5:0];
						SUB_PDOWN:    s_next.pdown    = data_s[5:0];
						SUB_LEVELS:   s_next.levels   = data_s[5:0];
						SUB_HOWLER:   s_next.howl     = data_s[5:0];
					endcase
				end
			endcase
		end

		// interrupt: frame-paced period, mclk-timed pulse width
		if (!s_reg.keys[INT_RELEASE])
			s_next.int_cnt = 6'h00;
		else if (frame_tick)
			s_next.int_cnt = (s_reg.int_cnt == INT_LAST) ? 6'h00 :
				s_reg.int_cnt + 6'h01;
		if (s_reg.keys[INT_RELEASE] && frame_tick &&
			s_reg.int_cnt == INT_LAST)
		begin
			s_next.pw_cnt = INT_LOW_CYC;
			s_next.irq_n  = 1'b0;
		end
		else if (s_reg.pw_cnt != 7'h00)
		begin
			s_next.pw_cnt = s_reg.pw_cnt - 7'h01;
			s_next.irq_n  = s_reg.pw_cnt == 7'h01;
		end

		// watchdog counts frames, so it stalls without frame sync
		if (wr_take && addr_s == ADDR_SUB && sub == SUB_LATCH &&
			data_s[WD_RESTART])
			s_next.wd_cnt = 12'h000;
		else if (frame_tick)
			s_next.wd_cnt = (s_reg.wd_cnt == WD_LAST) ? 12'h000 :
				s_reg.wd_cnt + 12'h001;
		s_next.wd_out = s_next.wd_cnt < WD_LOW_START;

		// sounder square wave, warbling between two tones
		if (!ring_on)
		begin
			s_next.tone_lvl   = 1'b0;
			s_next.tone_cnt   = 9'h000;
			s_next.warble_cnt = 9'h000;
			s_next.warble_ph  = 1'b0;
		end
		else if (frame_tick)
		begin
			if (s_reg.tone_cnt <= 9'h001)
			begin
				s_next.tone_cnt = tone_half;
				s_next.tone_lvl = !s_reg.tone_lvl;
			end
			else
				s_next.tone_cnt = s_reg.tone_cnt - 9'h001;
			if (s_reg.warble_cnt <= 9'h001)
			begin
				s_next.warble_cnt = tone.warble;
				s_next.warble_ph  = !s_reg.warble_ph;
			end
			else
				s_next.warble_cnt = s_reg.warble_cnt - 9'h001;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_reg            <= '0;
			s_reg.wr_prev    <= 1'b1;
			s_reg.volcombo   <= VOLCOMBO_RESET;
			s_reg.keys       <= REG8_RESET;
			s_reg.irq_n      <= 1'b1;
			s_reg.wd_out     <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign host_data_out         = s_reg.rd_data;
	assign host_data_oe_n        = !rd_active;
	assign key_scan_outputs      = '0;
	assign key_scan_oe_n         = ~s_reg.keys[KS_OUT_W-1:0];
	assign sounder_drive_pos     = s_reg.tone_lvl;
	assign sounder_drive_neg     = !s_reg.tone_lvl;
	assign ring_volume           = s_reg.volcombo[1:0];
	assign tone_combo            = combo_code;
	assign general_latch_outputs = s_reg.latch[3:0];
	assign internal_latch        = s_reg.latch[LATCH_INT_BIT];
	assign howler_flag           = s_reg.sounder[1:0] == SND_HOWL;
	assign periodic_irq_n        = s_reg.irq_n;
	assign watchdog_out          = s_reg.wd_out;
	assign master_clk_ext_sel    = s_reg.clk_sel;
	// frame-locked phase is the far end's job; level only passed on
	assign master_clk_ext_level  = s_reg.clk_level;
	assign fkey_tone_ctrl        = s_reg.fkey;
	assign pb_tone_ctrl          = s_reg.pb;
	assign channel_ctrl          = s_reg.chan;
	assign power_down_ctrl       = s_reg.pdown;
	assign level_ctrl            = s_reg.levels;
	assign howler_freq_ctrl      = s_reg.howl;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_sounder_inverse:
		assert property (sounder_drive_neg != sounder_drive_pos)
		else $error("sounder drives not complementary");
	a_sounder_idle:
		assert property (!ring_on |=> !sounder_drive_pos)
		else $error("sounder driven while off");
	a_howler_set:
		assert property (wr_take && addr_s == ADDR_SUB &&
			sub == SUB_SOUNDER && data_s[1:0] == SND_HOWL |=> howler_flag)
		else $error("howler flag not raised");
	a_latch_write:
		assert property (wr_take && addr_s == ADDR_SUB &&
			sub == SUB_LATCH |=>
			general_latch_outputs == $past(data_s[3:0]))
		else $error("latch outputs not updated");
	a_chan_write:
		assert property (wr_take && addr_s == ADDR_CHAN |=>
			channel_ctrl == $past(data_s))
		else $error("channel selector not written");
	a_keys_write:
		assert property (wr_take && addr_s == ADDR_KEYS |=>
			key_scan_oe_n == ~$past(data_s[KS_OUT_W-1:0]))
		else $error("key scan outputs not updated");
	a_read_data:
		assert property (!host_data_oe_n |->
			host_data_out == $past(keys_in_s))
		else $error("read data not key inputs");
	a_bus_quiet:
		assert property (ce_s || rd_s |-> host_data_oe_n)
		else $error("data bus driven outside read");
	a_ce_blocks:
		assert property (ce_s |=> $stable(s_reg.chan) &&
			$stable(s_reg.latch) && $stable(s_reg.keys))
		else $error("write taken without chip enable");
	a_irq_width:
		assert property ($fell(periodic_irq_n) |->
			##99 !periodic_irq_n ##1 periodic_irq_n)
		else $error("interrupt pulse width wrong");
	a_irq_frame:
		assert property ($fell(periodic_irq_n) |-> $past(frame_tick))
		else $error("interrupt without frame sync");
	a_wd_restart:
		assert property (wr_take && addr_s == ADDR_SUB &&
			sub == SUB_LATCH && data_s[WD_RESTART] |=>
			s_reg.wd_cnt == 12'h000 ##1 watchdog_out)
		else $error("watchdog restart ignored");

	c_read:    cover property (!host_data_oe_n);
	c_irq:     cover property ($fell(periodic_irq_n));
	c_howler:  cover property ($rose(howler_flag));
	c_wd_low:  cover property ($fell(watchdog_out));
endmodule // telephone_control_interface

// >>> host_bus_model.sv
// host processor model driving the codec control pins
// assumes the bench calls wr and rd; one call at a time
`timescale 1ns/1ps
module host_bus_model (
	input  wire logic       mclk,
	output logic            chip_enable_n,
	output logic            write_n,
	output logic            read_n,
	output logic            reg_addr_bit0,
	output logic            reg_addr_bit1,
	output logic [7:0]      host_data_in,
	input  wire logic [7:0] host_data_out,
	input  wire logic       host_data_oe_n
);
	logic       drv;
	logic [7:0] wdat;
	logic [7:0] last;

	// ------------------------------------------------------------
	// bus wire
	// ------------------------------------------------------------
	// no pull-ups: a released bus shows the inverse of its last level
	always_comb
	begin
		if (!host_data_oe_n)
			host_data_in = host_data_out;
		else if (drv)
			host_data_in = wdat;
		else
			host_data_in = ~last;
	end

	always @(posedge mclk)
		last <= host_data_in;

	initial
	begin
		chip_enable_n = 1'b1;
		write_n = 1'b1;
		read_n = 1'b1;
		{reg_addr_bit1, reg_addr_bit0} = 2'h0;
		drv = 1'b0;
		wdat = 8'h00;
		last = 8'h00;
	end

	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	// in wr, chip enable, address and data are held a few cycles around the strobe; rd sets them with the strobe
	// because the device synchronises the pins first
	task automatic wr(input logic [1:0] a, input logic [7:0] d,
		input logic ce_n);
		@(posedge mclk);
		chip_enable_n <= ce_n;
		{reg_addr_bit1, reg_addr_bit0} <= a;
		wdat <= d;
		drv <= 1'b1;
		repeat (4) @(posedge mclk);
		write_n <= 1'b0;
		repeat (4) @(posedge mclk);
		write_n <= 1'b1;
		repeat (6) @(posedge mclk);
		chip_enable_n <= 1'b1;
		drv <= 1'b0;
		@(posedge mclk);
		#1;
	endtask

	task automatic rd(input logic [1:0] a, output logic [7:0] d,
		output logic oe_n);
		@(posedge mclk);
		chip_enable_n <= 1'b0;
		read_n <= 1'b0;
		{reg_addr_bit1, reg_addr_bit0} <= a;
		repeat (8) @(posedge mclk);
		d = host_data_in;
		oe_n = host_data_oe_n;
		chip_enable_n <= 1'b1;
		read_n <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
	endtask
endmodule // host_bus_model

// >>> testbench.sv
// self-checking bench for the codec control interface
// assumes host_bus_model; frame sync runs compressed, 16 mclk a frame
`timescale 1ns/1ps
`define CHK(n, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			$display("FAIL %s exp %h got %h", n, e, g); \
			num_errors++; \
		end \
	end
module testbench;
	import codec_ctrl_pkg::*;
	logic mclk = 1'b0, resetn = 1'b0, chip_enable_n, write_n, read_n;
	logic reg_addr_bit0, reg_addr_bit1, host_data_oe_n, howler_flag;
	logic [7:0] host_data_in, host_data_out, channel_ctrl;
	logic [7:0] key_scan_inputs = 8'h00;
	logic [4:0] key_scan_outputs, key_scan_oe_n;
	logic tone_combo_select_low = 1'b0, tone_combo_select_high = 1'b0;
	logic frame_sync_8k = 1'b0, test_mode = 1'b0, ext_master_clock = 1'b0;
	logic sounder_drive_pos, sounder_drive_neg, internal_latch;
	logic periodic_irq_n, watchdog_out, master_clk_ext_sel;
	logic master_clk_ext_level;
	logic [1:0] ring_volume;
	logic [2:0] tone_combo;
	logic [3:0] general_latch_outputs;
	logic [5:0] fkey_tone_ctrl, pb_tone_ctrl, power_down_ctrl;
	logic [5:0] level_ctrl, howler_freq_ctrl;
	logic [3:0] fcnt = 4'h0;
	logic       fs_on = 1'b1;
	logic [7:0] rdat;
	logic       roe;
	logic       prev_pos;
	int num_errors = 0, cmp_count = 0, cycles = 0, t0, c, n;
	bit hit;

	always #5 mclk = ~mclk;

	// ------------------------------------------------------------
	// frame sync and external master clock
	// ------------------------------------------------------------
	// the master clock comes from the frame counter so it stays locked
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		fcnt <= fcnt + 4'h1;
		frame_sync_8k <= fs_on & (fcnt < 4'h8);
		ext_master_clock <= fcnt[1];
	end

	telephone_control_interface dut_u (.mclk, .resetn, .chip_enable_n,
		.write_n, .read_n, .reg_addr_bit0, .reg_addr_bit1, .host_data_in,
		.host_data_out, .host_data_oe_n, .key_scan_inputs,
		.key_scan_outputs, .key_scan_oe_n, .tone_combo_select_low,
		.tone_combo_select_high, .frame_sync_8k, .test_mode,
		.ext_master_clock, .sounder_drive_pos, .sounder_drive_neg,
		.ring_volume, .tone_combo, .general_latch_outputs,
		.internal_latch, .howler_flag, .periodic_irq_n, .watchdog_out,
		.master_clk_ext_sel, .master_clk_ext_level, .fkey_tone_ctrl,
		.pb_tone_ctrl, .channel_ctrl, .power_down_ctrl, .level_ctrl,
		.howler_freq_ctrl);

	host_bus_model host_u (.mclk, .chip_enable_n, .write_n, .read_n,
		.reg_addr_bit0, .reg_addr_bit1, .host_data_in, .host_data_out,
		.host_data_oe_n);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic close_out();
		if (num_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wait_sig(input bit s, input logic v, input int lim);
		int i;
		hit = 0;
		for (i = 0; i < lim && !hit; i++)
		begin
			@(posedge mclk);
			#1;
			hit = ((s ? watchdog_out : periodic_irq_n) === v);
		end
	endtask

	task automatic chk_reset();
		`CHK("ring_volume", 2'h3, ring_volume)
		`CHK("tone_combo", 3'h1, tone_combo)
		`CHK("key_scan_oe_n", 5'h1f, key_scan_oe_n)
		`CHK("howler_flag", 1'b0, howler_flag)
		`CHK("channel_ctrl", 8'h00, channel_ctrl)
		`CHK("general_latch", 4'h0, general_latch_outputs)
		`CHK("irq", 1'b1, periodic_irq_n)
		`CHK("oe_n", 1'b1, host_data_oe_n)
	endtask

	initial
	begin
		// tests need about 69000 cycles, the watchdog span dominating
		repeat (90000) @(posedge mclk);
		num_errors++;
		close_out();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk_reset();
		host_u.wr(ADDR_SUB, {SUB_FKEY, 6'h2a}, 1'b0);
		`CHK("fkey", 6'h2a, fkey_tone_ctrl)
		host_u.wr(ADDR_SUB, {SUB_PB, 6'h15}, 1'b0);
		`CHK("pb", 6'h15, pb_tone_ctrl)
		host_u.wr(ADDR_SUB, {SUB_LATCH, 6'h1a}, 1'b0);
		`CHK("latch", 4'ha, general_latch_outputs)
		`CHK("int_latch", 1'b1, internal_latch)
		`CHK("fkey", 6'h2a, fkey_tone_ctrl)
		host_u.wr(ADDR_CHAN, 8'hc5, 1'b0);
		`CHK("channel", 8'hc5, channel_ctrl)
		`CHK("latch", 4'ha, general_latch_outputs)
		host_u.wr(ADDR_CHAN, 8'h3c, 1'b1);
		`CHK("channel", 8'hc5, channel_ctrl)
		host_u.wr(ADDR_KEYS, 8'h55, 1'b0);
		`CHK("key_oe_n", 5'h0a, key_scan_oe_n)
		`CHK("key_out", 5'h00, key_scan_outputs)
		host_u.wr(ADDR_AUX, {SUB_PDOWN, 6'h31}, 1'b0);
		`CHK("pdown", 6'h31, power_down_ctrl)
		host_u.wr(ADDR_AUX, {SUB_LEVELS, 6'h0e}, 1'b0);
		`CHK("levels", 6'h0e, level_ctrl)
		host_u.wr(ADDR_AUX, {SUB_HOWLER, 6'h27}, 1'b0);
		`CHK("howl_freq", 6'h27, howler_freq_ctrl)
		for (c = 1; c <= 6; c++)
		begin
			host_u.wr(ADDR_AUX, {SUB_VOLCOMBO, 1'b0, 3'(c), 2'(c)}, 1'b0);
			`CHK("tone_combo", 3'(c), tone_combo)
			`CHK("ring_volume", 2'(c), ring_volume)
		end
		host_u.wr(ADDR_AUX, {SUB_VOLCOMBO, 1'b0, COMBO_EXT, 2'h3}, 1'b0);
		for (c = 0; c < 4; c++)
		begin
			{tone_combo_select_low, tone_combo_select_high} <= 2'(c);
			repeat (5) @(posedge mclk);
			#1;
			n = (c == 1) ? 2 : (c == 2) ? 3 : 1;
			`CHK("ext_combo", 3'(n), tone_combo)
		end
		// reads: key inputs only at the key address, never elsewhere
		key_scan_inputs <= 8'h96;
		host_u.rd(ADDR_KEYS, rdat, roe);
		`CHK("read_data", 8'h96, rdat)
		`CHK("read_oe_n", 1'b0, roe)
		host_u.rd(ADDR_SUB, rdat, roe);
		`CHK("read_oe_n", 1'b1, roe)
		// sounder: ringing with inverted pair, then howler flag
		host_u.wr(ADDR_SUB, {SUB_SOUNDER, 4'h0, SND_RING}, 1'b0);
		n = 0;
		prev_pos = sounder_drive_pos;
		for (c = 0; c < 300; c++)
		begin
			@(posedge mclk);
			#1;
			if (sounder_drive_pos !== sounder_drive_neg ^ 1'b1)
				n = n + 1000;
			if (sounder_drive_pos !== prev_pos)
				n++;
			prev_pos = sounder_drive_pos;
		end
		`CHK("sounder_toggles", 1'b1, (n >= 3 && n < 1000))
		host_u.wr(ADDR_SUB, {SUB_SOUNDER, 4'h0, SND_HOWL}, 1'b0);
		`CHK("howler_flag", 1'b1, howler_flag)
		host_u.wr(ADDR_SUB, {SUB_SOUNDER, 4'h0, SND_OFF}, 1'b0);
		`CHK("howler_flag", 1'b0, howler_flag)
		// clock mode reporting
		test_mode <= 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		`CHK("ext_sel", 1'b1, master_clk_ext_sel)
		test_mode <= 1'b0;
		repeat (6) @(posedge mclk);
		#1;
		`CHK("ext_sel", 1'b0, master_clk_ext_sel)
		`CHK("ext_level", 1'b0, master_clk_ext_level)
		// interrupt every 64 frames, pulse 100 cycles, none without sync
		host_u.wr(ADDR_KEYS, 8'h80, 1'b0);
		wait_sig(0, 1'b0, 2000);
		t0 = cycles;
		wait_sig(0, 1'b1, 300);
		`CHK("irq_width", 100, cycles - t0)
		wait_sig(0, 1'b0, 2000);
		`CHK("irq_period", 1024, cycles - t0)
		fs_on <= 1'b0;
		wait_sig(0, 1'b1, 300);
		wait_sig(0, 1'b0, 2000);
		`CHK("irq_no_sync", 1'b0, hit)
		fs_on <= 1'b1;
		// reset in mid-run returns every register to its start value
		resetn <= 1'b0;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk_reset();
		// watchdog restart, then 3968 frames high and 32 frames low
		host_u.wr(ADDR_SUB, {SUB_LATCH, 6'h20}, 1'b0);
		`CHK("watchdog", 1'b1, watchdog_out)
		t0 = cycles;
		wait_sig(1, 1'b0, 70000);
		n = cycles - t0;
		`CHK("wd_high", 1'b1, (n > 63464 && n < 63510))
		t0 = cycles;
		wait_sig(1, 1'b1, 1000);
		`CHK("wd_low", 512, cycles - t0)
		close_out();
	end
endmodule // testbench
